// ===== verilog/ebus_cycle_master.sv
module ebus_cycle_master
   import ebus_pkg::*;
(
   // Clock and reset
   input  wire logic                  REF_CLK,
   input  wire logic                  NRST,
   // Request side
   input  wire req_t                  REQ,
   input  wire logic                  REQ_VALID,
   input  wire logic [LINE_W-1:0]     REQ_WDATA,
   output logic                       REQ_READY,
   output logic [DATA_W-1:0]          RD_DATA,
   output logic                       RD_VALID,
   output logic                       DONE,
   // Per chip select configuration
   input  wire cs_cfg_t [7:0]         CS_CONFIG,
   // External bus
   output logic                       BUS_CLOCK_OUT,
   output logic [ADDR_W-1:0]          ADDR,
   output logic                       ADDR_OE,
   output logic                       READ_WRITE,
   output logic [1:0]                 TRANSFER_SIZE,
   output logic                       TRANSFER_START_N,
   output logic                       TRANSFER_IN_PROGRESS_N,
   input  wire logic                  TRANSFER_ACK_N,
   output logic [7:0]                 CHIP_SELECT_N,
   output logic [3:0]                 BYTE_SELECT_N,
   output logic                       OUTPUT_ENABLE_N,
   input  wire logic [DATA_W-1:0]     DATA_IN,
   output logic [DATA_W-1:0]          DATA_OUT,
   output logic                       DATA_OE
);

   // =======================================================================
   // Declarations
   bus_state_t          state_reg;
   bus_state_t          state_next;
   req_t                req_reg;
   cs_cfg_t             cfg;
   logic [LINE_W-1:0]   wdata_reg;
   logic [LINE_W-1:0]   wshift;
   logic [ADDR_W-1:0]   addr_reg;
   logic [ADDR_W-1:0]   addr_step;
   logic [4:0]          beats_reg;
   logic [3:0]          wait_reg;
   logic                burst_reg;
   logic                first_reg;
   logic                take;
   logic                fast;
   logic                ack;
   logic                beat;
   logic                more;
   logic                rest;
   logic                step_ok;
   logic [1:0]          cyc_size;

   // =======================================================================
   // Decode of the current access
   assign cfg  = CS_CONFIG[req_reg.chip];
   assign take = REQ_VALID && REQ_READY;
   assign more = beats_reg > 5'h01;
   // In the hold clock the count has already dropped for this beat
   assign rest = beats_reg != 5'h00;

   // Fast ack only counts when the slave terminates the cycle itself
   assign fast = (state_reg == STATE_ONE) && !cfg.internal_ack
                 && !TRANSFER_ACK_N;
   // Internal ack after the programmed waits, else the slave's ack
   assign ack  = cfg.internal_ack ? (wait_reg == 4'h0)
                                  : !TRANSFER_ACK_N;
   assign beat = fast || ((state_reg == STATE_THREE) && ack);

   // Line steps wrap inside the aligned line, so C leads to 0
   always_comb begin
      addr_step = addr_reg + ADDR_W'(size_bytes(cfg.port_size));
      if (req_reg.size == SIZE_LINE)
         addr_step = {addr_reg[ADDR_W-1:4],
                      addr_reg[3:0] + 4'(size_bytes(cfg.port_size))};
   end

   // Slave increments itself in bursts and line accesses under external termination
   assign step_ok = (burst_reg || req_reg.size == SIZE_LINE)
                    ? cfg.internal_ack : 1'b1;

   // Next write beat: bytes leave the top in transfer order
   always_comb begin
      unique case (cfg.port_size)
         SIZE_BYTE: wshift = wdata_reg << 8;
         SIZE_WORD: wshift = wdata_reg << 16;
         default:   wshift = wdata_reg << 32;
      endcase
   end

   // Size code: whole transfer in bursts, line first when inhibited
   always_comb begin
      if (!more && first_reg)
         cyc_size = req_reg.size;
      else if (burst_reg)
         cyc_size = req_reg.size;
      else if (first_reg && req_reg.size == SIZE_LINE)
         cyc_size = SIZE_LINE;
      else
         cyc_size = cfg.port_size;
   end

   // =======================================================================
   // State transitions: one state per reference clock, two per bus clock
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         STATE_IDLE:  if (take) state_next = STATE_ZERO;
         STATE_ZERO:  state_next = STATE_ONE;
         STATE_ONE:   state_next = fast ? STATE_FOUR : STATE_TWO;
         STATE_TWO:   state_next = STATE_THREE;
         STATE_THREE: begin
            if (!ack)
               state_next = STATE_TWO;
            else if (burst_reg && more)
               state_next = STATE_TWO;
            else
               state_next = STATE_FOUR;
         end
         STATE_FOUR:  state_next = STATE_FIVE;
         STATE_FIVE:  state_next = rest ? STATE_ZERO : STATE_IDLE;
         default:     state_next = STATE_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         state_reg <= STATE_IDLE;
      else
         state_reg <= state_next;
   end

   // =======================================================================
   // Bus clock: high in even states, low in odd states
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         BUS_CLOCK_OUT <= 1'b0;
      else
         BUS_CLOCK_OUT <= !BUS_CLOCK_OUT;
   end

   // A new cycle may only start on a rising bus clock edge
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         REQ_READY <= 1'b0;
      else
         REQ_READY <= (state_next == STATE_IDLE) && BUS_CLOCK_OUT;
   end

   // =======================================================================
   // Request capture and beat bookkeeping
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         req_reg   <= '0;
         wdata_reg <= '0;
         addr_reg  <= '0;
         beats_reg <= 5'h00;
         burst_reg <= 1'b0;
         first_reg <= 1'b0;
      end else if (take) begin
         req_reg   <= REQ;
         wdata_reg <= REQ_WDATA;
         addr_reg  <= REQ.addr;
         beats_reg <= beat_count(REQ.size,
                                 CS_CONFIG[REQ.chip].port_size);
         burst_reg <= (beat_count(REQ.size,
                                  CS_CONFIG[REQ.chip].port_size) > 5'h01)
                      && (REQ.write
                          ? CS_CONFIG[REQ.chip].burst_write_enable
                          : CS_CONFIG[REQ.chip].burst_read_enable);
         first_reg <= 1'b1;
      end else if (beat) begin
         wdata_reg <= wshift;
         beats_reg <= beats_reg - 5'h01;
         first_reg <= 1'b0;
         if (more)
            addr_reg <= addr_step;
      end else if (state_reg == STATE_FIVE) begin
         first_reg <= 1'b0;
      end
   end

   // Internal wait counter restarts for every cycle and burst beat
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         wait_reg <= 4'h0;
      else if (take)
         wait_reg <= CS_CONFIG[REQ.chip].wait_states;
      else if (state_next == STATE_ZERO || (beat && burst_reg))
         wait_reg <= cfg.wait_states;
      else if (state_reg == STATE_THREE && wait_reg != 4'h0)
         wait_reg <= wait_reg - 4'h1;
   end

   // =======================================================================
   // Address and attributes change on rising bus clock edges only
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         ADDR          <= '0;
         ADDR_OE       <= 1'b0;
         READ_WRITE    <= 1'b1;
         TRANSFER_SIZE <= SIZE_LONG;
      end else if (take) begin
         ADDR          <= REQ.addr;
         ADDR_OE       <= 1'b1;
         READ_WRITE    <= !REQ.write;
         TRANSFER_SIZE <= (beat_count(REQ.size,
                                      CS_CONFIG[REQ.chip].port_size)
                           > 5'h01)
                          && !(REQ.write
                               ? CS_CONFIG[REQ.chip].burst_write_enable
                               : CS_CONFIG[REQ.chip].burst_read_enable)
                          && REQ.size != SIZE_LINE
                          ? CS_CONFIG[REQ.chip].port_size : REQ.size;
      end else if (state_reg == STATE_FIVE && rest) begin
         // Split access: next piece, attributes held to this edge
         if (step_ok)
            ADDR       <= addr_reg;
         TRANSFER_SIZE <= cyc_size;
      end else if (state_reg == STATE_FIVE) begin
         ADDR_OE       <= 1'b0;
         READ_WRITE    <= 1'b1;
         TRANSFER_SIZE <= SIZE_LONG;
      end else if (state_reg == STATE_THREE && ack && burst_reg
                   && more && step_ok) begin
         ADDR          <= addr_step;
      end
   end

   // Start lasts exactly the first bus clock of each cycle
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         TRANSFER_START_N <= 1'b1;
      else if (state_next == STATE_ZERO)
         TRANSFER_START_N <= 1'b0;
      else if (state_reg == STATE_ONE)
         TRANSFER_START_N <= 1'b1;
   end

   // In-progress stays low across split pieces of one request
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         TRANSFER_IN_PROGRESS_N <= 1'b1;
      else if (state_next == STATE_ZERO)
         TRANSFER_IN_PROGRESS_N <= 1'b0;
      else if (state_reg == STATE_FIVE && !rest)
         TRANSFER_IN_PROGRESS_N <= 1'b1;
   end

   // =======================================================================
   // Selects move on falling bus clock edges, held through a burst
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHIP_SELECT_N   <= CS_IDLE;
         BYTE_SELECT_N   <= BS_IDLE;
         OUTPUT_ENABLE_N <= 1'b1;
      end else if (state_reg == STATE_ZERO) begin
         CHIP_SELECT_N   <= ~(8'h01 << req_reg.chip);
         BYTE_SELECT_N   <= ~byte_lanes(cfg.port_size, req_reg.size,
                                        addr_reg[1:0]);
         OUTPUT_ENABLE_N <= req_reg.write;
      end else if (state_reg == STATE_FOUR) begin
         CHIP_SELECT_N   <= CS_IDLE;
         BYTE_SELECT_N   <= BS_IDLE;
         OUTPUT_ENABLE_N <= 1'b1;
      end
   end

   // =======================================================================
   // Write data: on at the end of clock one, off when the cycle ends
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         DATA_OUT <= '0;
         DATA_OE  <= 1'b0;
      end else if (state_reg == STATE_ONE && req_reg.write) begin
         DATA_OUT <= wdata_reg[LINE_W-1 -: DATA_W];
         DATA_OE  <= 1'b1;
      end else if (state_reg == STATE_THREE && ack && burst_reg
                   && more && req_reg.write) begin
         DATA_OUT <= wshift[LINE_W-1 -: DATA_W];
      end else if (state_reg == STATE_FIVE) begin
         DATA_OE  <= 1'b0;
      end
   end

   // =======================================================================
   // Read data is taken on the edge that samples the ack
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         RD_DATA  <= '0;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= beat && !req_reg.write;
         if (beat && !req_reg.write)
            RD_DATA <= DATA_IN;
      end
   end

   // Completion pulse when the last hold clock ends
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         DONE <= 1'b0;
      else
         DONE <= (state_reg == STATE_FIVE) && !rest;
   end

endmodule : ebus_cycle_master

// ===== verilog/ebus_pkg.sv
// ==========================================================================
package ebus_pkg;

   // =======================================================================
   // Encodings and widths
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LINE = 2'h3;
   localparam int         ADDR_W    = 24;
   localparam int         DATA_W    = 32;
   localparam int         LINE_W    = 128;
   localparam logic [7:0] CS_IDLE   = 8'hff;
   localparam logic [3:0] BS_IDLE   = 4'hf;

   typedef struct packed {
      logic [1:0] port_size;      // Coded like a size: long, byte, word
      logic       internal_ack;
      logic [3:0] wait_states;
      logic       burst_read_enable;
      logic       burst_write_enable;
   } cs_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              write;
      logic [1:0]        size;
      logic [2:0]        chip;
   } req_t;

   typedef enum logic [6:0] {
      STATE_IDLE  = 7'h01,
      STATE_ZERO  = 7'h02,
      STATE_ONE   = 7'h04,
      STATE_TWO   = 7'h08,
      STATE_THREE = 7'h10,
      STATE_FOUR  = 7'h20,
      STATE_FIVE  = 7'h40
   } bus_state_t;

   // =======================================================================
   // Helpers
   function automatic logic [4:0] size_bytes(input logic [1:0] s);
      unique case (s)
         SIZE_BYTE: size_bytes = 5'h01;
         SIZE_WORD: size_bytes = 5'h02;
         SIZE_LONG: size_bytes = 5'h04;
         SIZE_LINE: size_bytes = 5'h10;
      endcase
   endfunction : size_bytes

   function automatic logic [4:0] beat_count(input logic [1:0] s,
                                             input logic [1:0] p);
      logic [4:0] sb;
      logic [4:0] pb;
      sb = size_bytes(s);
      pb = size_bytes(p);
      if (sb <= pb)
         beat_count = 5'h01;
      else if (pb == 5'h01)
         beat_count = sb;
      else if (pb == 5'h02)
         beat_count = sb >> 1;
      else
         beat_count = sb >> 2;
   endfunction : beat_count

   // Active-high lane set; the slave side sees the inverse
   function automatic logic [3:0] byte_lanes(input logic [1:0] p,
                                             input logic [1:0] s,
                                             input logic [1:0] a);
      byte_lanes = 4'hf;
      if (p == SIZE_BYTE)
         byte_lanes = 4'h8;
      else if (p == SIZE_WORD)
         byte_lanes = (s == SIZE_BYTE) ? (a[0] ? 4'h4 : 4'h8) : 4'hc;
      else if (s == SIZE_BYTE)
         byte_lanes = 4'h8 >> a;
      else if (s == SIZE_WORD)
         byte_lanes = a[1] ? 4'h3 : 4'hc;
   endfunction : byte_lanes

endpackage : ebus_pkg

// ===== testbench/ebus_bus_chk.sv
// ==========================================================================
// Bus cycle checker, ports of the cycle master only
module ebus_bus_chk
   import ebus_pkg::*;
(
   // Clock and reset
   input wire logic              REF_CLK,
   input wire logic              NRST,
   // Request side
   input wire logic              REQ_VALID,
   input wire logic              REQ_READY,
   input wire logic [DATA_W-1:0] RD_DATA,
   input wire logic              RD_VALID,
   input wire logic              DONE,
   // External bus
   input wire logic              BUS_CLOCK_OUT,
   input wire logic              ADDR_OE,
   input wire logic              READ_WRITE,
   input wire logic              TRANSFER_START_N,
   input wire logic              TRANSFER_IN_PROGRESS_N,
   input wire logic [7:0]        CHIP_SELECT_N,
   input wire logic              OUTPUT_ENABLE_N,
   input wire logic [DATA_W-1:0] DATA_IN,
   input wire logic [DATA_W-1:0] DATA_OUT,
   input wire logic              DATA_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   // One domain, so clock and reset are given once
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!NRST);

   // ========================================================================
   // Sequences and properties
   sequence s_ts_pulse;
      !TRANSFER_START_N ##1 TRANSFER_START_N;
   endsequence
   property p_take;
      REQ_VALID && REQ_READY |=> !TRANSFER_START_N && ADDR_OE;
   endproperty
   property p_ts;
      $fell(TRANSFER_START_N) |=> s_ts_pulse;
   endproperty
   property p_start;
      $fell(TRANSFER_START_N) |-> BUS_CLOCK_OUT && !TRANSFER_IN_PROGRESS_N;
   endproperty
   // Selects move in the low phase only, attributes in the high phase
   property p_sel;
      $changed(CHIP_SELECT_N) || $changed(OUTPUT_ENABLE_N) |-> !BUS_CLOCK_OUT;
   endproperty
   property p_attr;
      $changed(TRANSFER_IN_PROGRESS_N) || $changed(READ_WRITE) |-> BUS_CLOCK_OUT;
   endproperty
   property p_oe;
      !OUTPUT_ENABLE_N |-> READ_WRITE && CHIP_SELECT_N != CS_IDLE;
   endproperty
   property p_end;
      $rose(TRANSFER_IN_PROGRESS_N) |->
         DONE && !ADDR_OE && $past(ADDR_OE) && $past(CHIP_SELECT_N) == CS_IDLE;
   endproperty
   property p_wr;
      $rose(DATA_OE) |-> !READ_WRITE && $past(TRANSFER_START_N) == 1'b0;
   endproperty
   property p_wdata;
      DATA_OE && $changed(DATA_OUT) |-> BUS_CLOCK_OUT;
   endproperty
   property p_rdata;
      RD_VALID |-> RD_DATA == $past(DATA_IN);
   endproperty
   property p_ready;
      REQ_READY |-> !BUS_CLOCK_OUT && TRANSFER_IN_PROGRESS_N;
   endproperty

   // ========================================================================
   // Assertions
   a_take: assert property (p_take)
      else $error("start missing after take");
   a_ts: assert property (p_ts)
      else $error("start not one bus clock");
   a_start: assert property (p_start)
      else $error("start outside high phase");
   a_sel: assert property (p_sel)
      else $error("select moved in high phase");
   a_attr: assert property (p_attr)
      else $error("attribute moved in low phase");
   a_oe: assert property (p_oe)
      else $error("output enable off a read");
   a_end: assert property (p_end)
      else $error("cycle end out of order");
   a_wr: assert property (p_wr)
      else $error("write data driven late");
   a_wdata: assert property (p_wdata)
      else $error("write data unstable");
   a_rdata: assert property (p_rdata)
      else $error("read data not captured");
   a_ready: assert property (p_ready)
      else $error("ready in wrong phase");
endmodule : ebus_bus_chk

// ===== testbench/ebus_slave_model.sv
// ==========================================================================
// External slave: acks after a set number of low phases
module ebus_slave_model
   import ebus_pkg::*;
(
   // Clock and reset
   input  wire logic              REF_CLK,
   input  wire logic              NRST,
   // Pacing from the bench
   input  wire logic              FAST,
   input  wire logic [3:0]        WAITS,
   input  wire logic [4:0]        BEATS,
   // Bus
   input  wire logic              BUS_CLOCK_OUT,
   input  wire logic              TRANSFER_START_N,
   input  wire logic [ADDR_W-1:0] ADDR,
   output logic                   TRANSFER_ACK_N,
   output logic [DATA_W-1:0]      DATA_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   int left;
   int gap;

   // Ack and data stand for one low phase; lines toggle otherwise, so a
   // stale value never passes for read data
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         TRANSFER_ACK_N <= 1'b1;
         DATA_IN <= 32'h0000_0000;
         left = 0;
         gap = 0;
      end else begin
         if (BUS_CLOCK_OUT && !TRANSFER_START_N) begin
            left = BEATS;
            gap = FAST ? 0 : WAITS + 1;
         end
         if (BUS_CLOCK_OUT && left > 0 && gap == 0) begin
            TRANSFER_ACK_N <= 1'b0;
            DATA_IN <= {8'ha5, ADDR};
            left--;
            gap = WAITS;
         end else begin
            TRANSFER_ACK_N <= 1'b1;
            DATA_IN <= ~DATA_IN;
            if (BUS_CLOCK_OUT && left > 0)
               gap--;
         end
      end
   end
endmodule : ebus_slave_model

// ===== testbench/tb.sv
bind ebus_cycle_master ebus_bus_chk u_chk (.REF_CLK, .NRST, .REQ_VALID,
   .REQ_READY, .RD_DATA, .RD_VALID, .DONE, .BUS_CLOCK_OUT, .ADDR_OE,
   .READ_WRITE, .TRANSFER_START_N, .TRANSFER_IN_PROGRESS_N, .CHIP_SELECT_N,
   .OUTPUT_ENABLE_N, .DATA_IN, .DATA_OUT, .DATA_OE);

// ==========================================================================
// Bench top
module tb
   import ebus_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              ref_clk = 1'b0;
   logic              nrst = 1'b0;
   req_t              req = '0;
   logic              req_valid = 1'b0;
   logic [LINE_W-1:0] req_wdata = '0;
   cs_cfg_t [7:0]     cs_config = '0;
   logic              m_fast = 1'b0;
   logic [3:0]        m_wait = 4'h0;
   logic [4:0]        m_beats = 5'h01;
   logic              req_ready, rd_valid, done, bclk, ts_n, ack_n;
   logic [DATA_W-1:0] rd_data, data_in;
   logic [ADDR_W-1:0] addr;
   logic [1:0]        tsize;
   logic              ts_q = 1'b1;
   logic [31:0]       seed = 32'h8a48_e8e2;
   logic [31:0]       q_st[$], q_rd[$], q_done[$];
   int                fail_count = 0, tests_run = 0, cyc = 0, t0 = 0;

   always #5 ref_clk = ~ref_clk;

   ebus_cycle_master u_dut (
      .REF_CLK(ref_clk), .NRST(nrst), .REQ(req), .REQ_VALID(req_valid),
      .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RD_DATA(rd_data),
      .RD_VALID(rd_valid), .DONE(done), .CS_CONFIG(cs_config),
      .BUS_CLOCK_OUT(bclk), .ADDR(addr), .ADDR_OE(), .READ_WRITE(),
      .TRANSFER_SIZE(tsize), .TRANSFER_START_N(ts_n),
      .TRANSFER_IN_PROGRESS_N(), .TRANSFER_ACK_N(ack_n),
      .CHIP_SELECT_N(), .BYTE_SELECT_N(), .OUTPUT_ENABLE_N(),
      .DATA_IN(data_in), .DATA_OUT(), .DATA_OE());

   ebus_slave_model u_slave (.REF_CLK(ref_clk), .NRST(nrst), .FAST(m_fast),
      .WAITS(m_wait), .BEATS(m_beats), .BUS_CLOCK_OUT(bclk),
      .TRANSFER_START_N(ts_n), .ADDR(addr), .TRANSFER_ACK_N(ack_n),
      .DATA_IN(data_in));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic int nbytes(input int s);
      nbytes = (s == 0) ? 4 : (s == 3) ? 16 : s;
   endfunction : nbytes

   task automatic check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // ========================================================================
   // One request: note expectations, present it, wait for completion
   task automatic xfer(input int a, wr, sz, ps, ia, w, bst, fst);
      int n, per, al, k;
      logic [23:0] ad;
      logic [1:0] sc;
      n = (nbytes(sz) > nbytes(ps)) ? nbytes(sz) / nbytes(ps) : 1;
      per = (n > 1 && bst != 0) ? n : 1;
      ad = 24'(a);
      for (k = 0; k < n; k++) begin
         sc = (per > 1 || n == 1) ? 2'(sz) : (k == 0 && sz == 3) ? 2'h3 : 2'(ps);
         if (k % per == 0)
            q_st.push_back({6'h00, sc, ad});
         if (wr == 0)
            q_rd.push_back({8'ha5, ad});
         if (ia != 0 || (per == 1 && sz != 3))
            ad[3:0] = ad[3:0] + 4'(nbytes(ps));   // Wraps inside the line
      end
      al = ((fst != 0 && ia == 0) ? 2 : 4 + 2 * w) + (per - 1) * (2 + 2 * w);
      q_done.push_back(32'((n / per - 1) * (al + 2) + al + 3));
      seed = lfsr(seed);
      m_fast <= 1'(fst);
      m_wait <= 4'(w);
      m_beats <= 5'(per);
      cs_config <= {8{cs_cfg_t'{2'(ps), 1'(ia), 4'(w), 1'(bst), 1'(bst)}}};
      req <= '{24'(a), 1'(wr), 2'(sz), seed[2:0]};
      req_wdata <= {4{seed}};
      req_valid <= 1'b1;
      for (k = 0; k < 60; k++) begin
         @(posedge ref_clk);
         if (req_ready)
            break;
      end
      req_valid <= 1'b0;
      for (k = 0; k < 900 && !(done === 1'b1); k++)
         @(posedge ref_clk);
      if (k >= 900 || req_ready !== 1'b0 && k == 0) begin
         fail_count++;
         tally_and_finish();
      end
      repeat (2) @(posedge ref_clk);
   endtask : xfer

   // Watcher: each start, read beat and completion takes the oldest note
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      ts_q <= ts_n;
      if (req_valid && req_ready)
         t0 <= cyc;
      if (!ts_n && ts_q)
         check("start", {6'h00, tsize, addr}, q_st.pop_front());
      if (rd_valid)
         check("rdata", rd_data, q_rd.pop_front());
      if (done)
         check("done", 32'(cyc - t0), q_done.pop_front());
   end

   // Sizes: 0 long, 1 byte, 2 word, 3 line
   initial begin
      int i;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      xfer('h1000, 0, 0, 0, 0, 0, 0, 0);   // Basic read
      xfer('h1004, 1, 0, 0, 0, 2, 0, 0);   // Write with waits
      xfer('h1008, 0, 0, 0, 0, 0, 0, 1);   // Fast read
      xfer('h100c, 1, 2, 0, 0, 0, 0, 1);   // Fast write
      xfer('h2010, 1, 2, 0, 1, 1, 0, 1);   // Early ack ignored
      xfer('h302c, 0, 3, 0, 1, 0, 1, 0);   // Burst line from C
      xfer('h3038, 0, 3, 0, 0, 0, 0, 0);   // Inhibited, held
      xfer('h3044, 0, 3, 2, 1, 0, 0, 0);   // Inhibited, stepping
      xfer('h4000, 1, 0, 1, 0, 0, 1, 0);   // Burst to 8-bit port
      xfer('h5000, 0, 0, 2, 0, 1, 0, 0);   // Split on 16-bit port
      for (i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         xfer({seed[23:2], 2'b00}, seed[24], seed[26:25],
              seed[28:27] == 3 ? 0 : seed[28:27], seed[29], seed[5:4],
              seed[30], seed[31] & ~seed[29] & ~seed[30]);
      end
      tally_and_finish();
   end
endmodule : tb
